// ==== rtl/multi_subchannel_slot_map.sv ====
`timescale 1ns/100ps
`include "slot_map_defines.svh"

module multi_subchannel_slot_map
  import slot_map_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_sync,
  input  wire logic        rx_req,
  input  wire logic [7:0]  rx_byte,
  output rx_write_s        rx_wr,
  output logic             rx_wr_valid,
  output logic      [13:0] rx_param_ofs,
  input  wire logic        tx_sync,
  input  wire logic        tx_req,
  output logic      [7:0]  tx_byte,
  output logic             tx_byte_valid,
  output tx_fetch_s        tx_fetch,
  output logic             tx_fetch_valid,
  output logic      [13:0] tx_param_ofs,
  input  wire logic        tx_fetch_ack,
  input  wire logic [7:0]  tx_fetch_bits
);

  logic [15:0]  rx_map_reg [32];
  logic [15:0]  tx_map_reg [32];
  logic [15:0]  risc_config_reg;
  logic [15:0]  patch_trap_reg [4];
  logic [31:0]  serial_mode_high_reg;
  logic [31:0]  hdlc_enable_reg;
  logic [1:0]   control_reg;
  logic         rx_over_reg;
  logic         tx_over_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  walk_state_e  rx_state_reg;
  logic [4:0]   rx_idx_reg;
  logic         rx_wait_reg;
  logic [7:0]   rx_byte_reg;
  logic [2:0]   rx_ones_reg [32];
  rx_write_s    rx_wr_reg;
  logic         rx_wr_valid_reg;
  logic [13:0]  rx_param_ofs_reg;
  walk_state_e  tx_state_reg;
  logic [4:0]   tx_idx_reg;
  logic         tx_wait_reg;
  logic [7:0]   tx_acc_reg;
  logic [7:0]   tx_byte_reg;
  logic         tx_byte_valid_reg;
  tx_fetch_s    tx_fetch_reg;
  logic         tx_fetch_valid_reg;
  logic [13:0]  tx_param_ofs_reg;
  logic [11:0]  word_idx;
  logic         acc_cycle;
  logic         wr_take;
  logic         in_rx_map;
  logic         in_tx_map;
  logic [11:0]  rx_map_ofs;
  logic [11:0]  tx_map_ofs;
  logic         hit;
  logic [31:0]  rd_value;
  map_entry_s   rx_entry;
  logic [7:0]   rx_mask;
  logic [7:0]   rx_bits;
  logic [3:0]   rx_count;
  logic [2:0]   rx_ones_next;
  logic         rx_end;
  map_entry_s   tx_entry;
  logic [7:0]   tx_mask;
  logic [3:0]   tx_count;
  logic [7:0]   tx_acc_next;
  logic         tx_end;
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign rx_wr          = rx_wr_reg;
  assign rx_wr_valid    = rx_wr_valid_reg;
  assign rx_param_ofs   = rx_param_ofs_reg;
  assign tx_byte        = tx_byte_reg;
  assign tx_byte_valid  = tx_byte_valid_reg;
  assign tx_fetch       = tx_fetch_reg;
  assign tx_fetch_valid = tx_fetch_valid_reg;
  assign tx_param_ofs   = tx_param_ofs_reg;
  // apb decode; one wait state so read data can come from a flop
  assign word_idx   = paddr[13:2];
  assign acc_cycle  = psel & penable & ~pready_reg;
  assign wr_take    = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign rx_map_ofs = word_idx - `RX_SLOT_MAP_IDX;
  assign tx_map_ofs = word_idx - `TX_SLOT_MAP_IDX;
  assign in_rx_map  = (word_idx >= `RX_SLOT_MAP_IDX) && (rx_map_ofs < `SLOT_MAP_DEPTH);
  assign in_tx_map  = (word_idx >= `TX_SLOT_MAP_IDX) && (tx_map_ofs < `SLOT_MAP_DEPTH);

  always_comb
  begin
    hit      = 1'b1;
    rd_value = `REG_RESET_32;
    if (in_rx_map)
      rd_value = {16'h0000, rx_map_reg[rx_map_ofs[4:0]]};
    else if (in_tx_map)
      rd_value = {16'h0000, tx_map_reg[tx_map_ofs[4:0]]};
    else
      case (word_idx)
        `RISC_CONFIG_IDX:      rd_value = {16'h0000, risc_config_reg};
        `PATCH_TRAP_ONE_IDX:   rd_value = {16'h0000, patch_trap_reg[0]};
        `PATCH_TRAP_TWO_IDX:   rd_value = {16'h0000, patch_trap_reg[1]};
        `PATCH_TRAP_THREE_IDX: rd_value = {16'h0000, patch_trap_reg[2]};
        `PATCH_TRAP_FOUR_IDX:  rd_value = {16'h0000, patch_trap_reg[3]};
        `CONTROL_IDX:          rd_value = {30'h0000_0000, control_reg};
        `STATUS_IDX:           rd_value = {14'h0000, tx_over_reg, rx_over_reg, 4'h0,
                                           tx_wait_reg, rx_wait_reg, tx_idx_reg, rx_idx_reg};
        `SERIAL_MODE_HIGH_IDX: rd_value = serial_mode_high_reg;
        `HDLC_ENABLE_IDX:      rd_value = hdlc_enable_reg;
        default:               hit = 1'b0;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `REG_RESET_32;
    end
    else
    begin
      pready_reg  <= acc_cycle;
      pslverr_reg <= acc_cycle & ~hit;
      prdata_reg  <= (acc_cycle & ~pwrite & hit) ? rd_value : `REG_RESET_32;
    end
  end

  // software-visible storage; trap and serial mode words are held for the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        rx_map_reg[i] <= `REG_RESET_16;
        tx_map_reg[i] <= `REG_RESET_16;
      end
      for (int i = 0; i < 4; i++)
        patch_trap_reg[i] <= `REG_RESET_16;
      risc_config_reg      <= `REG_RESET_16;
      serial_mode_high_reg <= `REG_RESET_32;
      hdlc_enable_reg      <= `REG_RESET_32;
      control_reg          <= 2'b00;
    end
    else if (wr_take)
    begin
      if (in_rx_map)
        rx_map_reg[rx_map_ofs[4:0]] <= pwdata[15:0];
      else if (in_tx_map)
        tx_map_reg[tx_map_ofs[4:0]] <= pwdata[15:0];
      else
        case (word_idx)
          `RISC_CONFIG_IDX:      risc_config_reg      <= pwdata[15:0];
          `PATCH_TRAP_ONE_IDX:   patch_trap_reg[0]    <= pwdata[15:0];
          `PATCH_TRAP_TWO_IDX:   patch_trap_reg[1]    <= pwdata[15:0];
          `PATCH_TRAP_THREE_IDX: patch_trap_reg[2]    <= pwdata[15:0];
          `PATCH_TRAP_FOUR_IDX:  patch_trap_reg[3]    <= pwdata[15:0];
          `CONTROL_IDX:          control_reg          <= pwdata[1:0];
          `SERIAL_MODE_HIGH_IDX: serial_mode_high_reg <= pwdata;
          `HDLC_ENABLE_IDX:      hdlc_enable_reg      <= pwdata;
          default:               control_reg          <= control_reg;
        endcase
    end
  end

  // overrun flags: write one to clear, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_over_reg <= 1'b0;
      tx_over_reg <= 1'b0;
    end
    else
    begin
      if (rx_req && rx_state_reg != ST_IDLE)
        rx_over_reg <= 1'b1;
      else if (wr_take && word_idx == `STATUS_IDX && pwdata[`STAT_RX_OVER_BIT])
        rx_over_reg <= 1'b0;
      if (tx_req && tx_state_reg != ST_IDLE)
        tx_over_reg <= 1'b1;
      else if (wr_take && word_idx == `STATUS_IDX && pwdata[`STAT_TX_OVER_BIT])
        tx_over_reg <= 1'b0;
    end
  end

  // receive: extract the masked bits of the latched byte for the current entry
  assign rx_entry = map_entry_s'(rx_map_reg[rx_idx_reg]);
  assign rx_mask  = {rx_entry.mask_first, rx_entry.mask_rest};
  assign rx_end   = rx_entry.part_end | rx_entry.end_mark | (rx_idx_reg == `LAST_ENTRY);
  always_comb
  begin
    rx_bits      = 8'h00;
    rx_count     = 4'h0;
    rx_ones_next = rx_ones_reg[rx_entry.chan];
    // bit 7 is first on the line and pairs with mask bit 7
    for (int i = 7; i >= 0; i--)
    begin
      if (rx_mask[i])
      begin
        if (hdlc_enable_reg[rx_entry.chan] && rx_ones_next == `HDLC_STUFF_RUN
            && !rx_byte_reg[i])
          rx_ones_next = 3'd0;
        else
        begin
          rx_bits  = {rx_bits[6:0], rx_byte_reg[i]};
          rx_count = rx_count + 4'd1;
          if (!rx_byte_reg[i])
            rx_ones_next = 3'd0;
          else if (rx_ones_next != 3'd7)
            rx_ones_next = rx_ones_next + 3'd1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg     <= ST_IDLE;
      rx_idx_reg       <= 5'd0;
      rx_wait_reg      <= 1'b0;
      rx_byte_reg      <= 8'h00;
      rx_wr_reg        <= '0;
      rx_wr_valid_reg  <= 1'b0;
      rx_param_ofs_reg <= 14'h0000;
      for (int i = 0; i < 32; i++)
        rx_ones_reg[i] <= 3'd0;
    end
    else
    begin
      rx_wr_valid_reg <= 1'b0;
      case (rx_state_reg)
        ST_IDLE:
        begin
          if (rx_sync)
          begin
            rx_idx_reg  <= 5'd0;
            rx_wait_reg <= 1'b0;
          end
          if (rx_req && control_reg[`CTRL_RX_EN_BIT] && (rx_sync || !rx_wait_reg))
          begin
            rx_byte_reg  <= rx_byte;
            rx_state_reg <= ST_WALK;
          end
        end
        ST_WALK:
        begin
          // an invalid entry makes no write at all; index and end flags act as for any entry
          if (rx_entry.in_use)
          begin
            rx_wr_reg.chan_ptr <= {rx_entry.chan, 6'b00_0000};
            rx_wr_reg.bits     <= rx_bits;
            rx_wr_reg.count    <= rx_count;
            rx_wr_valid_reg    <= 1'b1;
            rx_param_ofs_reg   <= `PARAM_AREA_BASE
                                  + {3'b000, rx_entry.chan, 6'b00_0000};
            rx_ones_reg[rx_entry.chan] <= rx_ones_next;
          end
          if (rx_entry.end_mark || rx_idx_reg == `LAST_ENTRY)
          begin
            rx_idx_reg  <= 5'd0;
            rx_wait_reg <= 1'b1;
          end
          else
            rx_idx_reg <= rx_idx_reg + 5'd1;
          if (rx_end)
            rx_state_reg <= ST_IDLE;
        end
        default: rx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // transmit: walk entries, fetching bits for each unmasked position
  assign tx_entry = map_entry_s'(tx_map_reg[tx_idx_reg]);
  assign tx_mask  = {tx_entry.mask_first, tx_entry.mask_rest};
  assign tx_end   = tx_entry.part_end | tx_entry.end_mark | (tx_idx_reg == `LAST_ENTRY);
  always_comb
  begin
    tx_count    = 4'h0;
    tx_acc_next = tx_acc_reg;
    for (int i = 7; i >= 0; i--)
    begin
      if (tx_mask[i])
      begin
        tx_acc_next[i] = tx_fetch_bits[3'(7 - int'(tx_count))];
        tx_count       = tx_count + 4'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg       <= ST_IDLE;
      tx_idx_reg         <= 5'd0;
      tx_wait_reg        <= 1'b0;
      tx_acc_reg         <= 8'hFF;
      tx_byte_reg        <= 8'hFF;
      tx_byte_valid_reg  <= 1'b0;
      tx_fetch_reg       <= '0;
      tx_fetch_valid_reg <= 1'b0;
      tx_param_ofs_reg   <= 14'h0000;
    end
    else
    begin
      tx_byte_valid_reg  <= 1'b0;
      tx_fetch_valid_reg <= 1'b0;
      case (tx_state_reg)
        ST_IDLE:
        begin
          if (tx_sync)
          begin
            tx_idx_reg  <= 5'd0;
            tx_wait_reg <= 1'b0;
          end
          if (tx_req && control_reg[`CTRL_TX_EN_BIT] && (tx_sync || !tx_wait_reg))
          begin
            // masked and unused positions stay high
            tx_acc_reg   <= 8'hFF;
            tx_state_reg <= ST_WALK;
          end
        end
        ST_WALK:
        begin
          if (tx_entry.in_use && tx_mask != 8'h00)
          begin
            tx_fetch_reg.chan_ptr <= {tx_entry.chan, 6'b00_0000};
            tx_fetch_reg.count    <= tx_count;
            tx_fetch_valid_reg    <= 1'b1;
            tx_param_ofs_reg      <= `PARAM_AREA_BASE
                              + {3'b000, tx_entry.chan, 6'b00_0000};
            tx_state_reg          <= ST_FETCH;
          end
          else
          begin
            if (tx_entry.end_mark || tx_idx_reg == `LAST_ENTRY)
            begin
              tx_idx_reg  <= 5'd0;
              tx_wait_reg <= 1'b1;
            end
            else
              tx_idx_reg <= tx_idx_reg + 5'd1;
            if (tx_end)
            begin
              tx_byte_reg       <= tx_acc_reg;
              tx_byte_valid_reg <= 1'b1;
              tx_state_reg      <= ST_IDLE;
            end
          end
        end
        ST_FETCH:
        begin
          if (tx_fetch_ack)
          begin
            tx_acc_reg <= tx_acc_next;
            if (tx_entry.end_mark || tx_idx_reg == `LAST_ENTRY)
            begin
              tx_idx_reg  <= 5'd0;
              tx_wait_reg <= 1'b1;
            end
            else
              tx_idx_reg <= tx_idx_reg + 5'd1;
            if (tx_end)
            begin
              tx_byte_reg       <= tx_acc_next;
              tx_byte_valid_reg <= 1'b1;
              tx_state_reg      <= ST_IDLE;
            end
            else
              tx_state_reg <= ST_WALK;
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // multi_subchannel_slot_map

// ==== rtl/slot_map_defines.svh ====
// What this block does
// - rx invalid entry drops only its own bits
// - rx valid entry: zero deletion, write channel
// - rx wrap entry: restart entry zero at sync
// - tx wrap entry: restart entry zero at sync
// - rx last-part clear: next entry, same byte
// - tx builds one byte until last-part entry
// - param pointer is channel then six zeros
// - rx skips mask-zero bits, no counting
// - tx invalid entry sends all ones
// - tx unmasked bits from buffer, masked high
// - up to 32 channels, any slot permutation
// - split slot processed once per entry
// - param areas between base+2400h and 2BFFh
// - microcode owns first 1K, last 256 bytes
// - last-part flag sits at entry bit 11
`ifndef SLOT_MAP_DEFINES_SVH
`define SLOT_MAP_DEFINES_SVH

// register word indices; byte address is four times the index
`define RISC_CONFIG_IDX     12'h9C4
`define PATCH_TRAP_ONE_IDX  12'h9CC
`define PATCH_TRAP_TWO_IDX  12'h9CE
`define PATCH_TRAP_THREE_IDX 12'h9D0
`define PATCH_TRAP_FOUR_IDX 12'h9D2
`define CONTROL_IDX         12'h9E0
`define STATUS_IDX          12'h9E1
`define SERIAL_MODE_HIGH_IDX 12'h9E2
`define HDLC_ENABLE_IDX     12'h9E3
`define RX_SLOT_MAP_IDX     12'hA00
`define TX_SLOT_MAP_IDX     12'hA20
`define SLOT_MAP_DEPTH      12'h020

`define REG_RESET_16        16'h0000
`define REG_RESET_32        32'h0000_0000

// control fields
`define CTRL_RX_EN_BIT      0
`define CTRL_TX_EN_BIT      1
// status fields
`define STAT_RX_OVER_BIT    16
`define STAT_TX_OVER_BIT    17

// dual-ported ram layout with microcode resident
`define UCODE_AREA_SIZE     14'h0400
`define UCODE_DATA_SIZE     14'h0100
`define PARAM_AREA_BASE     14'h2400
`define PARAM_AREA_LAST     14'h2BFF

`define HDLC_STUFF_RUN      3'd5
`define LAST_ENTRY          5'd31

`endif

// ==== rtl/slot_map_pkg.sv ====
package slot_map_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WALK  = 2'b01,
    ST_FETCH = 2'b11
  } walk_state_e;

  // one slot map entry, from bit 15 down
  typedef struct packed {
    logic       in_use;
    logic       end_mark;
    logic [1:0] mask_first;
    logic       part_end;
    logic [4:0] chan;
    logic [5:0] mask_rest;
  } map_entry_s;

  typedef struct packed {
    logic [10:0] chan_ptr;
    logic [7:0]  bits;
    logic [3:0]  count;
  } rx_write_s;

  typedef struct packed {
    logic [10:0] chan_ptr;
    logic [3:0]  count;
  } tx_fetch_s;

endpackage

// ==== verif/slot_map_monitor.sv ====
`timescale 1ns/100ps
module slot_map_monitor
  import slot_map_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_req,
  input wire rx_write_s   rx_wr,
  input wire logic        rx_wr_valid,
  input wire logic [13:0] rx_param_ofs,
  input wire tx_fetch_s   tx_fetch,
  input wire logic        tx_fetch_valid,
  input wire logic [13:0] tx_param_ofs
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // saturating age of the last rx request; starts saturated so reset never fires
  logic [5:0] rx_since_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_since_reg <= 6'h3F;
    else if (rx_req)
      rx_since_reg <= 6'h00;
    else if (rx_since_reg != 6'h3F)
      rx_since_reg <= rx_since_reg + 6'h01;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  property p_apb_one_wait;
    s_setup ##1 s_access |=> pready;
  endproperty
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  property p_slverr_with_ready;
    pslverr |-> pready;
  endproperty
  property p_prdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  property p_rx_param;
    rx_wr_valid |-> rx_wr.chan_ptr[5:0] == 6'h00
      && rx_param_ofs == 14'h2400 + {3'h0, rx_wr.chan_ptr};
  endproperty
  property p_rx_bits_fit;
    rx_wr_valid |-> rx_wr.count <= 4'h8 && (rx_wr.bits >> rx_wr.count) == 8'h00;
  endproperty
  property p_rx_in_walk;
    rx_wr_valid |-> rx_since_reg <= 6'h22;
  endproperty
  property p_tx_param;
    tx_fetch_valid |-> tx_fetch.chan_ptr[5:0] == 6'h00
      && tx_param_ofs == 14'h2400 + {3'h0, tx_fetch.chan_ptr};
  endproperty
  property p_tx_count;
    tx_fetch_valid |-> tx_fetch.count inside {[4'h1:4'h8]};
  endproperty
  property p_tx_one_outstanding;
    tx_fetch_valid |=> !tx_fetch_valid;
  endproperty

  a_apb_one_wait: assert property (p_apb_one_wait)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held too long");
  a_slverr_with_ready: assert property (p_slverr_with_ready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (p_prdata_idle)
    else $error("prdata not zero outside answer");
  a_rx_param: assert property (p_rx_param)
    else $error("rx parameter pointer wrong");
  a_rx_bits_fit: assert property (p_rx_bits_fit)
    else $error("rx bits exceed count");
  a_rx_in_walk: assert property (p_rx_in_walk)
    else $error("rx write outside a walk");
  a_tx_param: assert property (p_tx_param)
    else $error("tx parameter pointer wrong");
  a_tx_count: assert property (p_tx_count)
    else $error("tx fetch count out of range");
  a_tx_one_outstanding: assert property (p_tx_one_outstanding)
    else $error("tx fetch repeated");
endmodule // slot_map_monitor

bind multi_subchannel_slot_map slot_map_monitor u_slot_map_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_req(rx_req),
  .rx_wr(rx_wr), .rx_wr_valid(rx_wr_valid), .rx_param_ofs(rx_param_ofs),
  .tx_fetch(tx_fetch), .tx_fetch_valid(tx_fetch_valid), .tx_param_ofs(tx_param_ofs)
);

// ==== verif/channel_buffer_model.sv ====
`timescale 1ns/100ps
module channel_buffer_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_fetch_valid,
  input  wire logic [3:0] slow,
  output logic            tx_fetch_ack,
  output logic      [7:0] tx_fetch_bits
);
  localparam logic [7:0] FILL_PATTERN = 8'hA5;
  logic       pend_reg;
  logic [3:0] wait_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg <= 1'b0;
      wait_reg <= 4'h0;
      tx_fetch_ack <= 1'b0;
      tx_fetch_bits <= ~FILL_PATTERN;
    end
    else
    begin
      tx_fetch_ack <= 1'b0;
      // released data toggles so the value one cycle after an answer never equals it; later stale cycles repeat it every other cycle
      tx_fetch_bits <= ~tx_fetch_bits;
      if (tx_fetch_valid)
      begin
        pend_reg <= 1'b1;
        wait_reg <= slow;
      end
      else if (pend_reg && wait_reg != 4'h0)
        wait_reg <= wait_reg - 4'h1;
      else if (pend_reg)
      begin
        pend_reg <= 1'b0;
        tx_fetch_ack <= 1'b1;
        tx_fetch_bits <= FILL_PATTERN;
      end
    end
  end
endmodule // channel_buffer_model

// ==== verif/multi_subchannel_slot_map_tb_top.sv ====
`timescale 1ns/100ps
`include "slot_map_defines.svh"
module multi_subchannel_slot_map_tb_top;
  import slot_map_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic        rx_sync, rx_req, rx_wr_valid, tx_sync, tx_req, tx_byte_valid;
  logic        tx_fetch_valid, tx_fetch_ack;
  logic [3:0]  slow;
  logic [7:0]  rx_byte, tx_byte, tx_fetch_bits;
  logic [13:0] paddr, rx_param_ofs, tx_param_ofs;
  logic [31:0] pwdata, prdata, rd;
  rx_write_s   rx_wr;
  tx_fetch_s   tx_fetch;
  logic [36:0] rxq[$];
  logic [28:0] txq[$];
  int          errors, checks;

  multi_subchannel_slot_map u_multi_subchannel_slot_map (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_sync(rx_sync), .rx_req(rx_req), .rx_byte(rx_byte), .rx_wr(rx_wr),
    .rx_wr_valid(rx_wr_valid), .rx_param_ofs(rx_param_ofs), .tx_sync(tx_sync),
    .tx_req(tx_req), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_fetch(tx_fetch), .tx_fetch_valid(tx_fetch_valid), .tx_param_ofs(tx_param_ofs),
    .tx_fetch_ack(tx_fetch_ack), .tx_fetch_bits(tx_fetch_bits));

  channel_buffer_model u_channel_buffer_model (
    .pclk(pclk), .presetn(presetn), .tx_fetch_valid(tx_fetch_valid), .slow(slow),
    .tx_fetch_ack(tx_fetch_ack), .tx_fetch_bits(tx_fetch_bits));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (rx_wr_valid === 1'b1)
      rxq.push_back({rx_param_ofs, rx_wr});
    if (tx_fetch_valid === 1'b1)
      txq.push_back({tx_param_ofs, tx_fetch});
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fail_stop();
    errors++;
    report_and_stop();
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    if (pready !== 1'b1)
      fail_stop();
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic reg_scn();
    logic [11:0] idx [6] = '{`RISC_CONFIG_IDX, `PATCH_TRAP_ONE_IDX, `PATCH_TRAP_TWO_IDX,
                             `PATCH_TRAP_THREE_IDX, `PATCH_TRAP_FOUR_IDX, `SERIAL_MODE_HIGH_IDX};
    logic [31:0] val [6] = '{32'h0000_0002, 32'h0000_8074, 32'h0000_8054,
                             32'h0000_92F2, 32'h0000_9097, 32'h0000_07A0};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, idx[i], 32'h0000_0000);
      check("reg reset value", rd, 32'h0000_0000);
      apb(1'b1, idx[i], val[i]);
      apb(1'b0, idx[i], 32'h0000_0000);
      check("reg read back", rd, val[i]);
    end
    apb(1'b0, 12'h9F0, 32'h0000_0000);
    check("unmapped slverr", last_err, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
  endtask

  task automatic rx_send(input logic s, input logic [7:0] b);
    rx_sync <= s;
    rx_req <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rx_sync <= 1'b0;
    rx_req <= 1'b0;
    rx_byte <= ~b;
    repeat (12) @(posedge pclk);
  endtask

  task automatic rx_pop(input logic [4:0] ch, input logic [7:0] b, input logic [3:0] c);
    logic [36:0] got;
    got = rxq.size() > 0 ? rxq.pop_front() : 'x;
    check("rx write", got, {14'h2400 + {3'h0, ch, 6'h00}, ch, 6'h00, b, c});
  endtask

  task automatic rx_scn();
    logic [15:0] map [6] = '{16'hB040, 16'h80B0, 16'h80CC, 16'h8903, 16'h397F, 16'hF9FF};
    for (int i = 0; i < 6; i++)
      apb(1'b1, `RX_SLOT_MAP_IDX + 12'(i), {16'h0000, map[i]});
    apb(1'b1, `HDLC_ENABLE_IDX, 32'h0000_0080);
    apb(1'b1, `CONTROL_IDX, 32'h0000_0003);
    rx_send(1'b1, 8'hB4);
    rx_send(1'b0, 8'hFF);
    rx_send(1'b0, 8'hFB);
    // no sync after the wrap entry, so this byte must vanish
    rx_send(1'b0, 8'h00);
    rx_send(1'b1, 8'h4B);
    rx_pop(5'h01, 8'h02, 4'h2);
    rx_pop(5'h02, 8'h03, 4'h2);
    rx_pop(5'h03, 8'h01, 4'h2);
    rx_pop(5'h04, 8'h00, 4'h2);
    rx_pop(5'h07, 8'h7F, 4'h7);
    rx_pop(5'h01, 8'h01, 4'h2);
    rx_pop(5'h02, 8'h00, 4'h2);
    rx_pop(5'h03, 8'h02, 4'h2);
    rx_pop(5'h04, 8'h03, 4'h2);
    check("rx extra writes", rxq.size(), 0);
    // second request lands mid-walk: flagged, dropped, walker still moves on
    rx_req <= 1'b1;
    repeat (2) @(posedge pclk);
    rx_req <= 1'b0;
    apb(1'b0, `STATUS_IDX, 32'h0000_0000);
    check("rx overrun status", rd, 32'h0001_0005);
    apb(1'b1, `STATUS_IDX, 32'h0001_0000);
    apb(1'b0, `STATUS_IDX, 32'h0000_0000);
    check("rx overrun cleared", rd, 32'h0000_0005);
  endtask

  task automatic tx_send(input logic s, input logic ans, input logic [7:0] exp);
    int n;
    n = 0;
    tx_sync <= s;
    tx_req <= 1'b1;
    @(posedge pclk);
    tx_sync <= 1'b0;
    tx_req <= 1'b0;
    while (tx_byte_valid !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    check("tx answered", n < 40, ans);
    if (ans)
      check("tx byte", tx_byte, exp);
    if (ans && n == 40)
      fail_stop();
    repeat (4) @(posedge pclk);
  endtask

  task automatic tx_pop(input logic [4:0] ch);
    logic [28:0] got;
    got = txq.size() > 0 ? txq.pop_front() : 'x;
    check("tx fetch", got, {14'h2400 + {3'h0, ch, 6'h00}, ch, 6'h00, 4'h4});
  endtask

  task automatic tx_scn();
    logic [15:0] map [3] = '{16'hB0B0, 16'h0800, 16'hC97C};
    for (int i = 0; i < 3; i++)
      apb(1'b1, `TX_SLOT_MAP_IDX + 12'(i), {16'h0000, map[i]});
    tx_send(1'b1, 1'b1, 8'hAF);
    slow <= 4'h6;
    tx_send(1'b0, 1'b1, 8'hEB);
    tx_send(1'b0, 1'b0, 8'hEB);
    tx_send(1'b1, 1'b1, 8'hAF);
    tx_pop(5'h02);
    tx_pop(5'h05);
    tx_pop(5'h02);
    check("tx extra fetches", txq.size(), 0);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    rx_sync = 1'b0;
    rx_req = 1'b0;
    rx_byte = 8'h00;
    tx_sync = 1'b0;
    tx_req = 1'b0;
    slow = 4'h0;
    errors = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    check("tx idle byte", tx_byte, 8'hFF);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_scn();
    rx_scn();
    tx_scn();
    report_and_stop();
  end
endmodule // multi_subchannel_slot_map_tb_top
